/* File: rtl/lir_pic.v */
// one legacy eight-level priority interrupt controller
`timescale 1ns/1ps
module lir_pic (
    input wire clk_i,
    input wire rst_b_i,
    input wire [7:0] req_i,
    input wire [7:0] mask_i,
    input wire ack_i,
    output reg int_o,
    output reg [2:0] vec_o
);
    reg [7:0] pend_r;
    reg [7:0] pend_nxt;
    reg [2:0] pri;
    reg hit;
    integer k;
    always @* begin
        pri = 3'h0;
        hit = 1'b0;
        for (k = 7; k >= 0; k = k - 1) begin
            if (pend_r[k] && !mask_i[k]) begin
                pri = k[2:0];
                hit = 1'b1;
            end
        end
        // set wins over the clear of an acknowledged level
        pend_nxt = pend_r;
        if (ack_i && hit)
            pend_nxt[pri] = 1'b0;
        pend_nxt = pend_nxt | req_i;
    end
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pend_r <= 8'h00;
            int_o <= 1'b0;
            vec_o <= 3'h0;
        end else begin
            pend_r <= pend_nxt;
            int_o <= hit;
            vec_o <= pri;
        end
    end
endmodule // lir_pic

/* File: rtl/lir_regs.vh */
// constants of the legacy and serial interrupt routing block
// Operation
// RULE1 - secondary levels 8-15 cascade into primary level 2
// RULE2 - one processor request line in legacy mode
// RULE3 - per-source map selects I/O APIC input
// RULE4 - accept PCI and IRQ requests, emit messages
// RULE5 - APIC mode watches all inputs, messages each event; code never sees IRQ_I[2] (level 2 forced low) or IRQ_I[8] (level 8 is RTC)
// RULE6 - more than sixteen APIC levels delivered
// RULE7 - cycle is start, at least 17 slots, stop
// RULE8 - quiet mode lets slaves start a cycle
// RULE9 - continuous mode: only host starts cycles
// RULE10 - up to 32 channels, 17 by default
// RULE11 - external serializer reports sixteen PCI requests; code takes eight, serial slots 16-23 as sources 24-31
// RULE12 - default map: timer, keyboard, cascade, mouse, IDE
// RULE13 - RTC request on level eight is active low
// RULE14 - drive system management interrupt to processors
// RULE15 - after stop, idle and latch sampled channel levels
`ifndef LIR_REGS_VH
`define LIR_REGS_VH
`define LIR_APIC_INPUTS 24
`define LIR_MAP_W 5
`define LIR_SER_CH_MIN 17
`define LIR_SER_CH_MAX 32
`define LIR_START_CLKS 4
`define LIR_STOP_CLKS 2
`define LIR_QUIET_STOP_CLKS 2
`define LIR_CONT_STOP_CLKS 3
`define LIR_SER_DIV 4
`define LIR_CASCADE_LVL 2
`define LIR_RTC_LVL 8
`define LIR_PCI_BASE 16
`endif

/* File: rtl/lir_serirq.v */
// serialized interrupt host: start, channel slots, stop, latch
`timescale 1ns/1ps
`include "lir_regs.vh"
module lir_serirq #(
    parameter CH = `LIR_SER_CH_MIN
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire tick_i,
    input wire cont_mode_i,
    input wire ser_in_i,
    output reg ser_out_o,
    output reg ser_oe_b_o,
    output reg [`LIR_SER_CH_MAX-1:0] lvl_o
);
    localparam S_IDLE = 5'h01;
    localparam S_START = 5'h02;
    localparam S_SLOT = 5'h04;
    localparam S_STOP = 5'h08;
    localparam S_RECOV = 5'h10;
    reg [4:0] st_r;
    reg [7:0] cnt_r;
    reg [1:0] ph_r;
    reg [`LIR_SER_CH_MAX-1:0] smp_r;
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= S_IDLE;
            cnt_r <= 8'h00;
            ph_r <= 2'h0;
            smp_r <= {`LIR_SER_CH_MAX{1'b1}};
            lvl_o <= {`LIR_SER_CH_MAX{1'b1}};
            ser_out_o <= 1'b1;
            ser_oe_b_o <= 1'b1;
        end else if (tick_i) begin
            case (st_r)
            S_IDLE: begin
                ser_oe_b_o <= 1'b1;
                // slaves may pull low in quiet mode only
                if (cont_mode_i || !ser_in_i) begin //RULE8 RULE9
                    st_r <= S_START; //RULE7
                    cnt_r <= 8'h00;
                    ser_out_o <= 1'b0;
                    ser_oe_b_o <= 1'b0;
                end
            end
            S_START: begin
                if (cnt_r == `LIR_START_CLKS - 1) begin
                    ser_out_o <= 1'b1;
                    ser_oe_b_o <= 1'b1;
                    st_r <= S_SLOT;
                    cnt_r <= 8'h00;
                    ph_r <= 2'h0;
                end else begin
                    cnt_r <= cnt_r + 8'h01;
                end
            end
            S_SLOT: begin
                // each slot: sample, recover, turnaround
                if (ph_r == 2'h0)
                    smp_r[cnt_r[4:0]] <= ser_in_i; //RULE10 RULE11
                if (ph_r == 2'h2) begin
                    ph_r <= 2'h0;
                    if (cnt_r == CH - 1) begin //RULE7 RULE10
                        st_r <= S_STOP;
                        cnt_r <= 8'h00;
                        ser_out_o <= 1'b0;
                        ser_oe_b_o <= 1'b0;
                    end else begin
                        cnt_r <= cnt_r + 8'h01;
                    end
                end else begin
                    ph_r <= ph_r + 2'h1;
                end
            end
            S_STOP: begin
                // stop width tells slaves the next mode
                if (cnt_r == (cont_mode_i ? `LIR_CONT_STOP_CLKS : `LIR_QUIET_STOP_CLKS) - 1) begin
                    ser_out_o <= 1'b1;
                    ser_oe_b_o <= 1'b1;
                    st_r <= S_RECOV;
                    lvl_o <= smp_r; //RULE15
                end else begin
                    cnt_r <= cnt_r + 8'h01;
                end
            end
            S_RECOV: begin
                st_r <= S_IDLE; //RULE15
                ser_oe_b_o <= 1'b1;
            end
            default: st_r <= S_IDLE;
            endcase
        end
    end
endmodule // lir_serirq

/* File: rtl/lir_top.v */
// legacy cascaded controllers, I/O APIC message path and serial IRQ host
`timescale 1ns/1ps
`include "lir_regs.vh"
module lir_top #(
    parameter SER_CH = `LIR_SER_CH_MIN,
    parameter NIN = `LIR_APIC_INPUTS
) (
    input wire CLOCK_I,
    input wire RST_B_I,
    input wire APIC_MODE_I,
    input wire SER_CONT_I,
    input wire [15:0] IRQ_I,
    input wire RTC_REQUEST_N_I,
    input wire [7:0] PCI_IRQ_N_I,
    input wire SYSTEM_MANAGEMENT_REQ_I,
    input wire INTA_ACK_I,
    input wire MAP_WE_I,
    input wire [4:0] MAP_SRC_I,
    input wire [4:0] MAP_DST_I,
    input wire [15:0] MASK_I,
    input wire MSG_READY_I,
    input wire SERIRQ_IN_I,
    output reg SERIRQ_OUT_O,
    output reg SERIRQ_OE_B_O,
    output reg PROCESSOR_INTERRUPT_REQUEST_O,
    output reg [7:0] INT_VECTOR_O,
    output reg SYSTEM_MANAGEMENT_INTERRUPT_O,
    output reg MSG_VALID_O,
    output reg [4:0] MSG_VECTOR_O
);
    // sources: 0-15 legacy IRQ, 16-23 PCI, 24-31 serial PCI scan
    localparam NSRC = 32;
    reg [1:0] div_r;
    wire tick = (div_r == 2'h0);
    wire ser_out;
    wire ser_oe_b;
    wire [31:0] ser_lvl;
    reg [15:0] irq_lvl;
    reg [NSRC-1:0] src_lvl;
    reg [NSRC-1:0] src_prev_r;
    reg [NSRC-1:0] evt_r;
    reg [NSRC-1:0] evt_nxt;
    reg [4:0] map_r [0:NSRC-1];
    wire [7:0] pri_req;
    wire [7:0] sec_req;
    wire pri_int;
    wire sec_int;
    wire [2:0] pri_vec;
    wire [2:0] sec_vec;
    reg [4:0] sel;
    reg sel_hit;
    wire casc_ack;
    reg casc_ack_r;
    integer i;
    always @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I)
            div_r <= 2'h0;
        else
            div_r <= (div_r == `LIR_SER_DIV - 1) ? 2'h0 : div_r + 2'h1;
    end
    lir_serirq #(.CH(SER_CH)) u_ser (
        .clk_i(CLOCK_I),
        .rst_b_i(RST_B_I),
        .tick_i(tick),
        .cont_mode_i(SER_CONT_I),
        .ser_in_i(SERIRQ_IN_I),
        .ser_out_o(ser_out),
        .ser_oe_b_o(ser_oe_b),
        .lvl_o(ser_lvl)
    );
    always @* begin
        // serial slot low means asserted; OR with direct pins
        irq_lvl = IRQ_I | ~ser_lvl[15:0];
        irq_lvl[`LIR_RTC_LVL] = ~RTC_REQUEST_N_I | ~ser_lvl[8]; //RULE13
        irq_lvl[`LIR_CASCADE_LVL] = 1'b0;
        src_lvl = {~ser_lvl[31:16] & 16'hFFFF, 16'h0000} & 32'hFF00_0000;
        src_lvl[23:16] = ~PCI_IRQ_N_I; //RULE4
        src_lvl[31:24] = ~ser_lvl[23:16]; //RULE11
        src_lvl[15:0] = irq_lvl; //RULE4
    end
    // legacy cascade: secondary output enters primary level 2
    assign sec_req = irq_lvl[15:8] & ~src_prev_r[15:8];
    // cascade is a level: hide it while the acknowledge drains through the secondary,
    // or the stale secondary line would re-pend level 2 with nothing behind it
    assign casc_ack = INTA_ACK_I && !APIC_MODE_I && pri_vec == `LIR_CASCADE_LVL;
    assign pri_req = {irq_lvl[7:3] & ~src_prev_r[7:3],
        sec_int && !casc_ack && !casc_ack_r, //RULE1
        irq_lvl[1:0] & ~src_prev_r[1:0]};
    lir_pic u_pic_pri (
        .clk_i(CLOCK_I),
        .rst_b_i(RST_B_I),
        .ack_i(INTA_ACK_I && !APIC_MODE_I),
        .req_i(pri_req),
        .mask_i(MASK_I[7:0]),
        .int_o(pri_int),
        .vec_o(pri_vec)
    );
    lir_pic u_pic_sec (
        .clk_i(CLOCK_I),
        .rst_b_i(RST_B_I),
        .ack_i(casc_ack),
        .req_i(sec_req),
        .mask_i(MASK_I[15:8]),
        .int_o(sec_int),
        .vec_o(sec_vec)
    );
    // apic path: edge on any source except cascade level 2 becomes one message
    always @* begin
        sel = 5'h00;
        sel_hit = 1'b0;
        for (i = NSRC - 1; i >= 0; i = i - 1) begin
            if (evt_r[i]) begin
                sel = i[4:0];
                sel_hit = 1'b1;
            end
        end
        evt_nxt = evt_r;
        if (sel_hit && (!MSG_VALID_O || MSG_READY_I))
            evt_nxt[sel] = 1'b0;
        if (APIC_MODE_I)
            evt_nxt = evt_nxt | (src_lvl & ~src_prev_r); //RULE5
    end
    always @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            src_prev_r <= {NSRC{1'b0}};
            evt_r <= {NSRC{1'b0}};
            MSG_VALID_O <= 1'b0;
            MSG_VECTOR_O <= 5'h00;
            for (i = 0; i < NSRC; i = i + 1)
                map_r[i] <= i[4:0] % NIN[4:0]; //RULE12
        end else begin
            src_prev_r <= src_lvl;
            evt_r <= evt_nxt;
            if (MAP_WE_I)
                map_r[MAP_SRC_I] <= MAP_DST_I; //RULE3
            if (!MSG_VALID_O || MSG_READY_I) begin
                MSG_VALID_O <= sel_hit; //RULE5
                MSG_VECTOR_O <= map_r[sel]; //RULE3 RULE6
            end
        end
    end
    always @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            PROCESSOR_INTERRUPT_REQUEST_O <= 1'b0;
            INT_VECTOR_O <= 8'h00;
            SYSTEM_MANAGEMENT_INTERRUPT_O <= 1'b0;
            SERIRQ_OUT_O <= 1'b1;
            SERIRQ_OE_B_O <= 1'b1;
            casc_ack_r <= 1'b0;
        end else begin
            // single shared line, only in legacy mode
            PROCESSOR_INTERRUPT_REQUEST_O <= pri_int && !APIC_MODE_I; //RULE2
            INT_VECTOR_O <= (pri_vec == `LIR_CASCADE_LVL) ? {5'h01, sec_vec} : {5'h00, pri_vec};
            SYSTEM_MANAGEMENT_INTERRUPT_O <= SYSTEM_MANAGEMENT_REQ_I; //RULE14
            casc_ack_r <= casc_ack; //RULE1
            SERIRQ_OUT_O <= ser_out;
            SERIRQ_OE_B_O <= ser_oe_b;
        end
    end
endmodule // lir_top

/* File: testbench/lir_props.sv */
// assertions on the ports of the interrupt routing block
`timescale 1ns/1ps
module lir_props (
    input wire logic CLOCK_I,
    input wire logic RST_B_I,
    input wire logic APIC_MODE_I,
    input wire logic SER_CONT_I,
    input wire logic [15:0] IRQ_I,
    input wire logic RTC_REQUEST_N_I,
    input wire logic SYSTEM_MANAGEMENT_REQ_I,
    input wire logic INTA_ACK_I,
    input wire logic [15:0] MASK_I,
    input wire logic MSG_READY_I,
    input wire logic SERIRQ_OUT_O,
    input wire logic SERIRQ_OE_B_O,
    input wire logic PROCESSOR_INTERRUPT_REQUEST_O,
    input wire logic SYSTEM_MANAGEMENT_INTERRUPT_O,
    input wire logic MSG_VALID_O,
    input wire logic [4:0] MSG_VECTOR_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RST_B_I);
    wire cpu_req = PROCESSOR_INTERRUPT_REQUEST_O;
    wire leg = !APIC_MODE_I && !MASK_I[2];
    property p_sysmgmt; SYSTEM_MANAGEMENT_REQ_I |=> SYSTEM_MANAGEMENT_INTERRUPT_O; endproperty
    a_sysmgmt: assert property (p_sysmgmt) else $error("management interrupt late");
    property p_quiet; APIC_MODE_I && $past(APIC_MODE_I) |-> !cpu_req; endproperty
    a_quiet: assert property (p_quiet) else $error("line in apic mode");
    // ack acts through three register stages, so the hold looks past them
    property p_hold;
        cpu_req && !APIC_MODE_I && !INTA_ACK_I && !$past(INTA_ACK_I) && !$past(INTA_ACK_I, 2)
        |=> cpu_req;
    endproperty
    a_hold: assert property (p_hold) else $error("line dropped");
    property p_msg; MSG_VALID_O && !MSG_READY_I |=> MSG_VALID_O && $stable(MSG_VECTOR_O); endproperty
    a_msg: assert property (p_msg) else $error("message lost");
    property p_ev; APIC_MODE_I && $rose(IRQ_I[4]) |-> ##[1:3] MSG_VALID_O; endproperty
    a_ev: assert property (p_ev) else $error("no message");
    property p_casc; leg && !MASK_I[9] && $rose(IRQ_I[9]) |-> ##[1:5] cpu_req; endproperty
    a_casc: assert property (p_casc) else $error("cascade");
    property p_rtc; leg && !MASK_I[8] && $fell(RTC_REQUEST_N_I) |-> ##[1:5] cpu_req; endproperty
    a_rtc: assert property (p_rtc) else $error("rtc");
    property p_start;
        SER_CONT_I && $fell(SERIRQ_OE_B_O) |-> (!SERIRQ_OE_B_O && !SERIRQ_OUT_O) [*8];
    endproperty
    a_start: assert property (p_start) else $error("start frame");
    property p_cont; SER_CONT_I |-> ##[1:400] (!SERIRQ_OE_B_O || !SER_CONT_I); endproperty
    a_cont: assert property (p_cont) else $error("host idle");
    c_msg: cover property (MSG_VALID_O && MSG_READY_I);
    c_ack: cover property (cpu_req && INTA_ACK_I);
    c_ser: cover property ($fell(SERIRQ_OE_B_O));
endmodule // lir_props
bind lir_top lir_props u_props (.*);

/* File: testbench/lir_slave.sv */
// serial interrupt slave: opens quiet cycles and pulls one slot low
`timescale 1ns/1ps
module lir_slave (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic line_i,
    input wire logic start_i,
    input wire logic en_i,
    input wire logic [4:0] slot_i,
    output logic drv_n_o
);
    logic line_r;
    logic busy_r;
    int cnt_r;
    int lo;
    assign lo = 16 + 12 * slot_i;
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            line_r <= 1'b1;
            busy_r <= 1'b0;
            cnt_r <= 1;
            drv_n_o <= 1'b1;
        end else begin
            line_r <= line_i;
            cnt_r <= busy_r ? cnt_r + 1 : 1;
            if (line_r && !line_i)
                busy_r <= 1'b1;
            if (cnt_r == 224)
                busy_r <= 1'b0;
            // wide window tolerates a tick of offset from the host
            drv_n_o <= !((start_i && (!busy_r || cnt_r < 4))
                || (busy_r && en_i && cnt_r >= lo && cnt_r < lo + 8));
        end
    end
endmodule // lir_slave

/* File: testbench/tb_legacy_and_serial_irq_routing.sv */
// self-checking bench of the interrupt routing block
`timescale 1ns/1ps
module tb_legacy_and_serial_irq_routing;
    logic CLOCK_I = 0;
    logic RST_B_I = 0;
    logic APIC_MODE_I, SER_CONT_I, RTC_REQUEST_N_I, SYSTEM_MANAGEMENT_REQ_I;
    logic INTA_ACK_I, MAP_WE_I;
    logic MSG_READY_I, start, en, drv_n, SERIRQ_OUT_O, SERIRQ_OE_B_O, MSG_VALID_O;
    logic PROCESSOR_INTERRUPT_REQUEST_O, SYSTEM_MANAGEMENT_INTERRUPT_O;
    logic [15:0] IRQ_I, MASK_I;
    logic [7:0] PCI_IRQ_N_I, INT_VECTOR_O;
    logic [4:0] MAP_SRC_I, MAP_DST_I, MSG_VECTOR_O, slot;
    // released line floats to its pull-up
    wire SERIRQ_IN_I = (SERIRQ_OE_B_O ? 1'b1 : SERIRQ_OUT_O) & drv_n;
    wire cpu_req = PROCESSOR_INTERRUPT_REQUEST_O;
    int num_errors = 0;
    int checked = 0;
    always #5 CLOCK_I = ~CLOCK_I;
    lir_top u_dut (.*);
    lir_slave u_slave (.clk_i(CLOCK_I), .rst_b_i(RST_B_I), .line_i(SERIRQ_IN_I),
        .start_i(start), .en_i(en), .slot_i(slot), .drv_n_o(drv_n));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wait_hi(input bit msg, input int n);
        // look after the edge so a launching flop has settled
        #1;
        for (int i = 0; i < n && (msg ? MSG_VALID_O : cpu_req) !== 1'b1; i++) begin
            @(posedge CLOCK_I);
            #1;
        end
    endtask
    task ack;
        @(posedge CLOCK_I) INTA_ACK_I <= 1'b1;
        IRQ_I <= 16'h0000;
        RTC_REQUEST_N_I <= 1'b1;
        @(posedge CLOCK_I) INTA_ACK_I <= 1'b0;
        repeat (3) @(posedge CLOCK_I);
        #1 check({7'h00, cpu_req}, 8'h00);
    endtask
    task fire(input logic [15:0] irq, input logic rtc_n, input logic [7:0] vec);
        @(posedge CLOCK_I) IRQ_I <= irq;
        RTC_REQUEST_N_I <= rtc_n;
        wait_hi(0, 6);
        check(INT_VECTOR_O, vec);
        ack;
    endtask
    task take(input logic [7:0] vec);
        wait_hi(1, 8);
        repeat (2) @(posedge CLOCK_I);
        #1 check({3'h0, MSG_VECTOR_O}, vec);
        @(posedge CLOCK_I) MSG_READY_I <= 1'b1;
        @(posedge CLOCK_I) MSG_READY_I <= 1'b0;
    endtask
    task t_basic;
        #1 check({5'h00, SERIRQ_OUT_O, SERIRQ_OE_B_O, MSG_VALID_O}, 8'h06);
        @(posedge CLOCK_I) SYSTEM_MANAGEMENT_REQ_I <= 1'b1;
        IRQ_I <= 16'h0008;
        @(posedge CLOCK_I) SYSTEM_MANAGEMENT_REQ_I <= 1'b0;
        #1 check({7'h00, SYSTEM_MANAGEMENT_INTERRUPT_O}, 8'h01);
        repeat (6) @(posedge CLOCK_I);
        #1 check({6'h00, SYSTEM_MANAGEMENT_INTERRUPT_O, cpu_req}, 8'h00);
    endtask
    task t_serial;
        @(posedge CLOCK_I) SER_CONT_I <= 1'b1;
        en <= 1'b1;
        slot <= 5'h05;
        wait_hi(0, 600);
        check(INT_VECTOR_O, 8'h05);
        ack;
        @(posedge CLOCK_I) SER_CONT_I <= 1'b0;
        repeat (300) @(posedge CLOCK_I);
        slot <= 5'h06;
        start <= 1'b1;
        repeat (6) @(posedge CLOCK_I);
        start <= 1'b0;
        wait_hi(0, 400);
        check(INT_VECTOR_O, 8'h06);
        ack;
    endtask
    task t_apic;
        @(posedge CLOCK_I) APIC_MODE_I <= 1'b1;
        MAP_WE_I <= 1'b1;
        MAP_SRC_I <= 5'h05;
        MAP_DST_I <= 5'h14;
        @(posedge CLOCK_I) MAP_WE_I <= 1'b0;
        IRQ_I <= 16'h0030;
        PCI_IRQ_N_I <= 8'hFE;
        take(8'h04);
        take(8'h14);
        take(8'h10);
        #1 check({7'h00, cpu_req}, 8'h00);
    endtask
    task final_report;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        {APIC_MODE_I, SER_CONT_I, SYSTEM_MANAGEMENT_REQ_I, INTA_ACK_I, MAP_WE_I, MSG_READY_I} = '0;
        {start, en, slot, MAP_SRC_I, MAP_DST_I, IRQ_I} = '0;
        RTC_REQUEST_N_I = 1'b1;
        MASK_I = 16'h0008;
        PCI_IRQ_N_I = 8'hFF;
        repeat (10) @(posedge CLOCK_I);
        RST_B_I <= 1'b1;
        t_basic;
        fire(16'h0002, 1'b1, 8'h01);
        fire(16'h0200, 1'b1, 8'h09);
        fire(16'h0000, 1'b0, 8'h08);
        t_serial;
        t_apic;
        final_report;
    end
    initial begin
        #200000;
        num_errors++;
        final_report;
    end
endmodule // tb_legacy_and_serial_irq_routing
